/* File: rtl/sfe_defs.svh */
// Opcodes, frame lengths and timing constants of the erase sequencer.
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH

`define SFE_OP_WRITE_ENABLE_CMD_EN       8'h06
`define SFE_OP_SECTOR        8'h20
`define SFE_OP_SECTOR_WIDE   8'h21
`define SFE_OP_E32           8'h52
`define SFE_OP_E32_WIDE      8'h5C
`define SFE_OP_E64           8'hD8
`define SFE_OP_E64_WIDE      8'hDC
`define SFE_OP_CHIP_A        8'h60
`define SFE_OP_CHIP_B        8'hC7
`define SFE_OP_DEEP_SLEEP    8'hB9
`define SFE_OP_WAKE          8'hAB
`define SFE_OP_UNIQUE_ID     8'h4B
`define SFE_OP_RESET_EN      8'h66
`define SFE_OP_RESET         8'h99

`define SFE_OPCODE_BITS      8'h08
`define SFE_FRAME_ADDR3      8'h20
`define SFE_FRAME_ADDR4      8'h28
`define SFE_UID_START3       8'h28
`define SFE_UID_START4       8'h30
`define SFE_UID_BITS         8'h80
`define SFE_ADDR_WIDTH_BIT   8

`define SFE_SECTOR_MASK      32'hFFFF_F000
`define SFE_E32_MASK         32'hFFFF_8000
`define SFE_E64_MASK         32'hFFFF_0000
`define SFE_BLK64_COUNT      10'h200
`define SFE_BLK64_LSB        16

`define SFE_CLK_MHZ          40
`define SFE_SECTOR_TIME_US   30000
`define SFE_BLOCK_TIME_US    150000
`define SFE_FULL_TIME_US     20000000
`define SFE_DP_ENTRY_TIME_US 3
`define SFE_RELEASE_TIME_US  30
`define SFE_SECTOR_CYC       (`SFE_SECTOR_TIME_US * `SFE_CLK_MHZ)
`define SFE_BLOCK_CYC        (`SFE_BLOCK_TIME_US * `SFE_CLK_MHZ)
`define SFE_FULL_CYC         (`SFE_FULL_TIME_US * `SFE_CLK_MHZ)
`define SFE_DP_ENTRY_CYC     32'(`SFE_DP_ENTRY_TIME_US * `SFE_CLK_MHZ)
`define SFE_RELEASE_CYC      32'(`SFE_RELEASE_TIME_US * `SFE_CLK_MHZ)

`endif

/* File: rtl/sfe_pkg.sv */
// Types shared by the erase sequencer.
package sfe_pkg;

	typedef enum logic [2:0] {
		SFE_IDLE     = 3'b000,
		SFE_ERASE    = 3'b001,
		SFE_DP_ENTRY = 3'b010,
		SFE_DP       = 3'b011,
		SFE_DP_EXIT  = 3'b100
	} sfe_state_t;

	typedef enum logic [1:0] {
		SFE_K_SECTOR = 2'b00,
		SFE_K_32K    = 2'b01,
		SFE_K_64K    = 2'b10,
		SFE_K_CHIP   = 2'b11
	} sfe_kind_t;

	typedef struct packed {
		logic top_bottom_select;
		logic block_protect_3;
		logic block_protect_2;
		logic block_protect_1;
		logic block_protect_0;
	} sfe_protect_t;

	typedef struct packed {
		logic        start;
		sfe_kind_t   kind;
		logic [31:0] base;
	} sfe_erase_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       so;
		logic       so_en;
	} sfe_frame_t;

	typedef struct packed {
		logic [7:0]  op;
		logic [31:0] addr;
		logic [7:0]  nbits;
		logic        seq;
		logic        seen_s1;
		logic        seen_s2;
		logic        ads_s1;
		logic        ads_s2;
		logic        dp_s1;
		logic        dp_s2;
	} sfe_capture_t;

	typedef struct packed {
		sfe_state_t  state;
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_s3;
		logic        seq_seen;
		logic        write_enable_latch;
		logic        rst_en;
		logic [31:0] cnt;
		sfe_erase_t  erase;
	} sfe_core_t;

endpackage

/* File: rtl/sfe_seq.sv */
// Erase, deep power-down and unique ID sequencer of a serial NOR flash.
`timescale 1ns/1ps
`include "sfe_defs.svh"

module sfe_seq #(
	parameter int unsigned   SECTOR_ERASE_CYC = `SFE_SECTOR_CYC,
	parameter int unsigned   BLOCK_ERASE_CYC  = `SFE_BLOCK_CYC,
	parameter int unsigned   FULL_ERASE_CYC   = `SFE_FULL_CYC,
	// Arbitrary identifier value; real parts program their own.
	parameter logic [127:0]  UNIQUE_ID        = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 sclk_i,
	input  wire logic                 cs_n_i,
	input  wire logic                 si_i,
	output logic                      so_o,
	output logic                      so_oe_o,
	input  wire logic                 addr_width_flag_i,
	input  wire sfe_pkg::sfe_protect_t protect_i,
	input  wire logic                 other_busy_i,
	output logic                      write_in_progress_o,
	output logic                      write_enable_latch_o,
	output logic                      deep_sleep_o,
	output logic                      standby_o,
	output sfe_pkg::sfe_erase_t       erase_o
);

	sfe_pkg::sfe_frame_t   fr_q;
	sfe_pkg::sfe_frame_t   fr_d;
	sfe_pkg::sfe_capture_t cap_q;
	sfe_pkg::sfe_capture_t cap_d;
	sfe_pkg::sfe_core_t    core_q;
	sfe_pkg::sfe_core_t    core_d;

	// Picks one identifier bit, most significant bit first.
	function automatic logic uid_bit(input logic [7:0] idx);
		logic [6:0] pos;
		pos = 7'h7F - idx[6:0];
		return UNIQUE_ID[pos];
	endfunction

	// True when the 64KB block holding the address is write protected.
	function automatic logic blk_protected(input logic [31:0] addr,
	                                       input sfe_pkg::sfe_protect_t p);
		logic [3:0] bp;
		logic [9:0] n;
		logic [9:0] blk;
		bp  = {p.block_protect_3, p.block_protect_2,
		       p.block_protect_1, p.block_protect_0};
		blk = {1'b0, addr[`SFE_BLK64_LSB +: 9]};
		if (bp == 4'h0) begin
			n = 10'h000;
		end else if (bp >= 4'hA) begin
			n = `SFE_BLK64_COUNT;
		end else begin
			n = 10'(10'h001 << (bp - 4'h1));
		end
		if (n == 10'h000) begin
			return 1'b0;
		end else if (p.top_bottom_select) begin
			return blk < n;
		end else begin
			return blk >= (`SFE_BLK64_COUNT - n);
		end
	endfunction

	function automatic logic any_protected(input sfe_pkg::sfe_protect_t p);
		return p.block_protect_3 | p.block_protect_2 |
		       p.block_protect_1 | p.block_protect_0;
	endfunction

	// Link side. The frame counter is cleared by the select pin itself
	// because the serial clock stands still between frames.
	always_comb begin
		logic [7:0] start;
		logic [7:0] idx;
		start = `SFE_UID_START3;
		idx   = 8'h00;
		fr_d  = fr_q;
		cap_d = cap_q;
		cap_d.ads_s1 = addr_width_flag_i;
		cap_d.ads_s2 = cap_q.ads_s1;
		cap_d.dp_s1  = (core_q.state == sfe_pkg::SFE_DP);
		cap_d.dp_s2  = cap_q.dp_s1;
		cap_d.seen_s1 = core_q.seq_seen;
		cap_d.seen_s2 = cap_q.seen_s1;
		// The link side has no reset, so the frame tag is not toggled
		// from itself. It is set at the third edge from the core's last
		// seen tag, after two link flip-flops. Shorter frames are void.
		if (fr_q.cnt == 8'h02) begin
			cap_d.seq = ~cap_q.seen_s2;
		end
		if (fr_q.cnt < `SFE_OPCODE_BITS) begin
			cap_d.op = {cap_q.op[6:0], si_i};
		end else if (fr_q.cnt < `SFE_FRAME_ADDR4) begin
			cap_d.addr = {cap_q.addr[30:0], si_i};
		end
		if (fr_q.cnt != 8'hFF) begin
			fr_d.cnt = fr_q.cnt + 8'h01;
		end
		cap_d.nbits = fr_d.cnt;
		if (cap_q.ads_s2) begin
			start = `SFE_UID_START4;
		end
		idx = fr_d.cnt - start;
		fr_d.so_en = 1'b0;
		if (cap_q.op == `SFE_OP_UNIQUE_ID && !cap_q.dp_s2 &&
		    fr_d.cnt >= start && idx < `SFE_UID_BITS) begin
			fr_d.so_en = 1'b1;
			fr_d.so    = uid_bit(idx);
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// Captured words stay put once select rises; the core reads them
	// only after its own synchronised copy of select has risen.
	always_ff @(posedge sclk_i) begin
		cap_q <= cap_d;
	end

	assign so_o    = fr_q.so;
	assign so_oe_o = fr_q.so_en;

	// Core side.
	always_comb begin
		logic        rise;
		logic [7:0]  need;
		logic [31:0] addr;
		logic [31:0] mask;
		logic [31:0] cyc;
		logic        region;
		sfe_pkg::sfe_kind_t kind;
		core_d = core_q;
		core_d.erase.start = 1'b0;
		core_d.cs_s1 = cs_n_i;
		core_d.cs_s2 = core_q.cs_s1;
		core_d.cs_s3 = core_q.cs_s2;
		rise   = core_q.cs_s2 & ~core_q.cs_s3 &
		         (cap_q.seq != core_q.seq_seen);
		need   = addr_width_flag_i ? `SFE_FRAME_ADDR4
		                           : `SFE_FRAME_ADDR3;
		region = 1'b1;
		kind   = sfe_pkg::SFE_K_SECTOR;
		mask   = `SFE_SECTOR_MASK;
		cyc    = 32'(SECTOR_ERASE_CYC);
		// Only a frame with a fresh tag is consumed, so an unset tag
		// after power-up never reaches the core's copy.
		if (rise) begin
			core_d.seq_seen = cap_q.seq;
		end
		unique case (cap_q.op)
			`SFE_OP_SECTOR: begin
			end
			`SFE_OP_SECTOR_WIDE: begin
				need = `SFE_FRAME_ADDR4;
			end
			`SFE_OP_E32: begin
				kind = sfe_pkg::SFE_K_32K;
				mask = `SFE_E32_MASK;
				cyc  = 32'(BLOCK_ERASE_CYC);
			end
			`SFE_OP_E32_WIDE: begin
				kind = sfe_pkg::SFE_K_32K;
				mask = `SFE_E32_MASK;
				cyc  = 32'(BLOCK_ERASE_CYC);
				need = `SFE_FRAME_ADDR4;
			end
			`SFE_OP_E64: begin
				kind = sfe_pkg::SFE_K_64K;
				mask = `SFE_E64_MASK;
				cyc  = 32'(BLOCK_ERASE_CYC);
			end
			`SFE_OP_E64_WIDE: begin
				kind = sfe_pkg::SFE_K_64K;
				mask = `SFE_E64_MASK;
				cyc  = 32'(BLOCK_ERASE_CYC);
				need = `SFE_FRAME_ADDR4;
			end
			default: begin
				region = 1'b0;
			end
		endcase
		// A three-byte frame leaves stale bits above bit 23.
		addr = (need == `SFE_FRAME_ADDR3) ? {8'h00, cap_q.addr[23:0]}
		                                  : cap_q.addr;
		addr = addr & mask;
		unique case (core_q.state)
			sfe_pkg::SFE_IDLE: begin
				if (rise) begin
					core_d.rst_en = 1'b0;
					if (region) begin
						if (cap_q.nbits == need && core_q.write_enable_latch &&
						    !other_busy_i &&
						    !blk_protected(addr, protect_i)) begin
							core_d.state       = sfe_pkg::SFE_ERASE;
							core_d.cnt         = cyc;
							core_d.write_enable_latch         = 1'b0;
							core_d.erase.start = 1'b1;
							core_d.erase.kind  = kind;
							core_d.erase.base  = addr;
						end
					end else if (cap_q.nbits == `SFE_OPCODE_BITS) begin
						if ((cap_q.op == `SFE_OP_CHIP_A ||
						     cap_q.op == `SFE_OP_CHIP_B) &&
						    core_q.write_enable_latch && !other_busy_i &&
						    !any_protected(protect_i)) begin
							core_d.state       = sfe_pkg::SFE_ERASE;
							core_d.cnt         = 32'(FULL_ERASE_CYC);
							core_d.write_enable_latch         = 1'b0;
							core_d.erase.start = 1'b1;
							core_d.erase.kind  = sfe_pkg::SFE_K_CHIP;
							core_d.erase.base  = 32'h0000_0000;
						end else if (cap_q.op == `SFE_OP_DEEP_SLEEP &&
						             !other_busy_i) begin
							core_d.state = sfe_pkg::SFE_DP_ENTRY;
							core_d.cnt   = `SFE_DP_ENTRY_CYC;
						end else if (cap_q.op == `SFE_OP_WRITE_ENABLE_CMD_EN &&
						             !other_busy_i) begin
							core_d.write_enable_latch = 1'b1;
						end else if (cap_q.op == `SFE_OP_RESET_EN) begin
							core_d.rst_en = 1'b1;
						end else if (cap_q.op == `SFE_OP_RESET &&
						             core_q.rst_en) begin
							core_d.write_enable_latch = 1'b0;
						end
					end
				end
			end
			sfe_pkg::SFE_ERASE: begin
				// Frames during the cycle are dropped; only status
				// reads, handled elsewhere, are meaningful now.
				if (core_q.cnt <= 32'h0000_0001) begin
					core_d.state = sfe_pkg::SFE_IDLE;
					core_d.cnt   = 32'h0000_0000;
				end else begin
					core_d.cnt = core_q.cnt - 32'h0000_0001;
				end
			end
			sfe_pkg::SFE_DP_ENTRY: begin
				if (core_q.cnt <= 32'h0000_0001) begin
					core_d.state = sfe_pkg::SFE_DP;
					core_d.cnt   = 32'h0000_0000;
				end else begin
					core_d.cnt = core_q.cnt - 32'h0000_0001;
				end
			end
			sfe_pkg::SFE_DP: begin
				if (rise) begin
					core_d.rst_en = 1'b0;
					if (cap_q.op == `SFE_OP_WAKE &&
					    cap_q.nbits >= `SFE_OPCODE_BITS) begin
						core_d.state = sfe_pkg::SFE_DP_EXIT;
						core_d.cnt   = `SFE_RELEASE_CYC;
					end else if (cap_q.op == `SFE_OP_RESET_EN &&
					             cap_q.nbits == `SFE_OPCODE_BITS) begin
						core_d.rst_en = 1'b1;
					end else if (cap_q.op == `SFE_OP_RESET &&
					             cap_q.nbits == `SFE_OPCODE_BITS &&
					             core_q.rst_en) begin
						core_d.state = sfe_pkg::SFE_IDLE;
						core_d.write_enable_latch   = 1'b0;
					end
				end
			end
			sfe_pkg::SFE_DP_EXIT: begin
				if (core_q.cnt <= 32'h0000_0001) begin
					core_d.state = sfe_pkg::SFE_IDLE;
					core_d.cnt   = 32'h0000_0000;
				end else begin
					core_d.cnt = core_q.cnt - 32'h0000_0001;
				end
			end
			default: begin
				core_d.state = sfe_pkg::SFE_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			core_q       <= '0;
			core_q.cs_s1 <= 1'b1;
			core_q.cs_s2 <= 1'b1;
			core_q.cs_s3 <= 1'b1;
		end else begin
			core_q <= core_d;
		end
	end

	assign write_in_progress_o  = (core_q.state == sfe_pkg::SFE_ERASE);
	assign write_enable_latch_o = core_q.write_enable_latch;
	assign deep_sleep_o         = (core_q.state == sfe_pkg::SFE_DP);
	assign standby_o            = core_q.cs_s2 &&
	                              core_q.state == sfe_pkg::SFE_IDLE;
	assign erase_o              = core_q.erase;

endmodule // sfe_seq

/* File: test/sfe_host.sv */
// Host serial controller model that frames commands to the sequencer.
`timescale 1ns/1ps
module sfe_host (
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	// The frame counter is cleared only by a rising select edge, so
	// select starts low and is raised once before any frame.
	initial begin
		cs_n_o = 1'b0;
		sclk_o = 1'b0;
		si_o = 1'b0;
		#1 cs_n_o = 1'b1;
	end

	// The clock stands low between frames; a released data line toggles.
	task automatic frame(input logic [7:0] op, input logic [39:0] tail,
		input int ntail, input int nrd, output logic [127:0] rd);
		logic [47:0] sh;
		sh = {op, tail << (40 - ntail)};
		rd = '0;
		#37.3 cs_n_o = 1'b0;
		for (int e = 0; e < 8 + ntail + nrd; e++) begin
			si_o = (e < 8 + ntail) ? sh[47 - e] : ~si_o;
			#62.5;
			if (e >= 8 + ntail)
				rd = {rd[126:0], so_oe_i ? so_i : 1'bx};
			sclk_o = 1'b1;
			#62.5 sclk_o = 1'b0;
		end
		#40 cs_n_o = 1'b1;
		si_o = ~si_o;
		#150;
	endtask
endmodule // sfe_host

/* File: test/sfe_seq_assertions.sv */
// Concurrent checks on the ports of the erase sequencer.
`timescale 1ns/1ps
module sfe_seq_assertions #(
	parameter int unsigned SECTOR_ERASE_CYC = 50,
	parameter int unsigned BLOCK_ERASE_CYC  = 80,
	parameter int unsigned FULL_ERASE_CYC   = 120
) (
	input wire logic                  ref_clk_i,
	input wire logic                  rst_i,
	input wire logic                  sclk_i,
	input wire logic                  cs_n_i,
	input wire logic                  si_i,
	input wire logic                  so_o,
	input wire logic                  so_oe_o,
	input wire logic                  addr_width_flag_i,
	input wire sfe_pkg::sfe_protect_t protect_i,
	input wire logic                  other_busy_i,
	input wire logic                  write_in_progress_o,
	input wire logic                  write_enable_latch_o,
	input wire logic                  deep_sleep_o,
	input wire logic                  standby_o,
	input wire sfe_pkg::sfe_erase_t   erase_o
);
	int unsigned busy_cnt;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			busy_cnt <= 0;
		else
			busy_cnt <= write_in_progress_o ? busy_cnt + 1 : 0;
	end

	chk_start_pulse: assert property (erase_o.start |=> !erase_o.start)
		else $error("erase start longer than one cycle");
	chk_start_state: assert property (erase_o.start |->
		write_in_progress_o && !write_enable_latch_o)
		else $error("erase start without busy or with latch set");
	chk_start_select: assert property (erase_o.start |->
		cs_n_i && $past(cs_n_i, 2))
		else $error("erase started while selected");
	chk_busy_hold: assert property ($rose(write_in_progress_o) |->
		write_in_progress_o[*8])
		else $error("busy flag dropped early");
	chk_busy_length: assert property ($fell(write_in_progress_o) |->
		busy_cnt >= SECTOR_ERASE_CYC && busy_cnt <= FULL_ERASE_CYC)
		else $error("erase cycle length out of range");
	chk_sector_align: assert property (erase_o.start &&
		erase_o.kind == sfe_pkg::SFE_K_SECTOR |->
		erase_o.base[11:0] == 12'h000)
		else $error("sector base not aligned");
	chk_block_align: assert property (erase_o.start &&
		erase_o.kind == sfe_pkg::SFE_K_64K |->
		erase_o.base[15:0] == 16'h0000)
		else $error("64k base not aligned");
	chk_sleep_quiet: assert property (deep_sleep_o |->
		!write_in_progress_o && !erase_o.start)
		else $error("activity in deep sleep");
	chk_sleep_delay: assert property ($rose(deep_sleep_o) |->
		$past(cs_n_i, 100))
		else $error("deep sleep entered too soon");
	chk_idle_standby: assert property (standby_o |->
		!write_in_progress_o)
		else $error("standby during erase cycle");
	chk_id_select: assert property (so_oe_o |-> !cs_n_i)
		else $error("identifier driven while deselected");

	cover property (erase_o.start && erase_o.kind == sfe_pkg::SFE_K_CHIP);
	cover property ($rose(deep_sleep_o));
	cover property ($fell(so_oe_o));
endmodule // sfe_seq_assertions

/* File: test/sfe_seq_tb.sv */
// Self-checking bench of the erase and deep sleep sequencer.
`timescale 1ns/1ps
module sfe_seq_tb;
	localparam logic [127:0] UID = 128'h5A5A_0F0F_C3C3_9669_1234_ABCD_0001_FFFE;
	logic                  ref_clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  wide_mode = 1'b0;
	logic                  busy = 1'b0;
	sfe_pkg::sfe_protect_t prot = '0;
	wire                   cs_n, sclk, si, so, so_oe, wprog, wlatch, dsl;
	wire                   stby;
	sfe_pkg::sfe_erase_t   er;
	logic [127:0]          rd;
	int                    n_fail = 0;
	int                    comparisons = 0;

	always #12.5 ref_clk_i = ~ref_clk_i;

	sfe_host host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so),
		.so_oe_i(so_oe));
	sfe_seq #(.SECTOR_ERASE_CYC(50), .BLOCK_ERASE_CYC(80),
		.FULL_ERASE_CYC(120), .UNIQUE_ID(UID)) uut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
		.addr_width_flag_i(wide_mode), .protect_i(prot),
		.other_busy_i(busy), .write_in_progress_o(wprog),
		.write_enable_latch_o(wlatch), .deep_sleep_o(dsl),
		.standby_o(stby), .erase_o(er));

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Optional write enable, then one erase frame; go is the model's verdict.
	task automatic erase(input logic write_enable_cmd, input logic [7:0] op,
		input logic [31:0] a, input int nb, input int k, input logic go);
		logic [31:0] mask;
		int n;
		int len;
		logic st;
		mask = k == 0 ? 32'hFFFF_F000 : k == 1 ? 32'hFFFF_8000 :
			k == 2 ? 32'hFFFF_0000 : 32'h0000_0000;
		if (write_enable_cmd) begin
			host.frame(8'h06, '0, 0, 0, rd);
			check(wlatch, 1'b1);
		end
		n = 0;
		len = 0;
		st = 1'b0;
		// The start pulse comes while the frame task still waits out the
		// gap after select rises, so it is watched alongside the frame.
		fork
			host.frame(op, {8'h00, a}, nb, 0, rd);
			begin
				while (er.start !== 1'b1 && n < 400) begin
					@(negedge ref_clk_i);
					n++;
				end
				st = er.start;
				while (st && wprog === 1'b1 && len < 300) begin
					@(negedge ref_clk_i);
					len++;
				end
			end
		join
		check(st, go);
		if (go) begin
			check({er.kind, er.base, wlatch}, {k[1:0], a & mask, 1'b0});
			check(len, k == 0 ? 50 : k == 3 ? 120 : 80);
			check(stby, 1'b1);
		end
	endtask

	initial begin
		logic [7:0] ops[8] = '{8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC,
			8'h60, 8'hC7};
		int unsigned s;
		int w;
		logic [31:0] a;
		s = $urandom(32'h06EB);
		repeat (4) @(negedge ref_clk_i);
		rst_i = 1'b0;
		check({wprog, wlatch, dsl, stby}, 4'h1);
		for (int m = 0; m < 2; m++) begin
			wide_mode = m[0];
			for (int i = 0; i < 8; i++) begin
				w = (i % 2) | m;
				a = $urandom & (w != 0 ? 32'h01FF_FFFF : 32'h00FF_FFFF);
				erase(1'b1, ops[i], a, i > 5 ? 0 : w != 0 ? 32 : 24,
					i > 5 ? 3 : i / 2, 1'b1);
			end
		end
		wide_mode = 1'b0;
		erase(1'b0, 8'h20, 32'h0000_1000, 24, 0, 1'b0);
		erase(1'b1, 8'h52, 32'h0000_8000, 23, 1, 1'b0);
		erase(1'b1, 8'hD8, 32'h0001_0000, 32, 2, 1'b0);
		erase(1'b1, 8'h60, 32'h0000_0000, 8, 3, 1'b0);
		prot = 5'h01;
		erase(1'b1, 8'h21, 32'h01FF_1234, 32, 0, 1'b0);
		erase(1'b1, 8'hC7, 32'h0000_0000, 0, 3, 1'b0);
		erase(1'b1, 8'h21, 32'h0000_1234, 32, 0, 1'b1);
		prot = '0;
		busy = 1'b1;
		host.frame(8'hB9, '0, 0, 0, rd);
		repeat (130) @(negedge ref_clk_i);
		check(dsl, 1'b0);
		busy = 1'b0;
		host.frame(8'hB9, '0, 8, 0, rd);
		repeat (130) @(negedge ref_clk_i);
		check(dsl, 1'b0);
		host.frame(8'hB9, '0, 0, 0, rd);
		repeat (100) @(negedge ref_clk_i);
		check(dsl, 1'b0);
		repeat (30) @(negedge ref_clk_i);
		check(dsl, 1'b1);
		host.frame(8'h06, '0, 0, 0, rd);
		check({dsl, wlatch}, 2'h2);
		host.frame(8'hAB, '0, 0, 0, rd);
		check(dsl, 1'b0);
		repeat (1210) @(negedge ref_clk_i);
		for (int m = 0; m < 2; m++) begin
			wide_mode = m[0];
			host.frame(8'h4B, '0, 32 + 8 * m, 128, rd);
			check(rd, UID);
			@(negedge ref_clk_i);
		end
		host.frame(8'hB9, '0, 0, 0, rd);
		repeat (130) @(negedge ref_clk_i);
		host.frame(8'h66, '0, 0, 0, rd);
		check(dsl, 1'b1);
		host.frame(8'h99, '0, 0, 0, rd);
		check({dsl, stby}, 2'h1);
		report_and_stop();
	end

	initial begin
		#2ms;
		n_fail++;
		report_and_stop();
	end
endmodule // sfe_seq_tb

bind sfe_seq sfe_seq_assertions #(.SECTOR_ERASE_CYC(SECTOR_ERASE_CYC),
	.BLOCK_ERASE_CYC(BLOCK_ERASE_CYC), .FULL_ERASE_CYC(FULL_ERASE_CYC)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
	.si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.addr_width_flag_i(addr_width_flag_i), .protect_i(protect_i),
	.other_busy_i(other_busy_i), .write_in_progress_o(write_in_progress_o),
	.write_enable_latch_o(write_enable_latch_o),
	.deep_sleep_o(deep_sleep_o), .standby_o(standby_o), .erase_o(erase_o));
